// *** rtl/dma_chan_pkg.sv ***
`default_nettype none
package dma_chan_pkg;

   localparam int ADDR_W = 8;
   localparam int CNT_W  = 16;

   // register byte offsets on the control bus
   localparam logic [7:0] OFF_ENABLE   = 8'h00;
   localparam logic [7:0] OFF_SOURCE   = 8'h04;
   localparam logic [7:0] OFF_ADDR_CTL = 8'h08;
   localparam logic [7:0] OFF_FORMAT   = 8'h0c;
   localparam logic [7:0] OFF_FLAG     = 8'h10;
   localparam logic [7:0] OFF_INTEN    = 8'h14;
   localparam logic [7:0] OFF_SRC_PTR  = 8'h18;
   localparam logic [7:0] OFF_DST_PTR  = 8'h1c;
   localparam logic [7:0] OFF_COUNT    = 8'h20;
   localparam logic [7:0] OFF_STATUS   = 8'h24;
   localparam logic [7:0] OFF_MASK     = 8'h28;

   // field positions
   localparam int ENABLE_BIT   = 0;
   localparam int DST_AREA_LSB = 0;
   localparam int DST_MODE_LSB = 6;
   localparam int SRC_AREA_LSB = 8;
   localparam int SRC_MODE_LSB = 14;
   localparam int CATEGORY_LSB = 0;
   localparam int UNIT_LSB     = 8;
   localparam int SCHEME_LSB   = 12;
   localparam int CLR_SEL_BIT  = 0;
   localparam int END_IE_BIT   = 4;
   localparam int END_BIT      = 0;

   // field encodings
   localparam logic [1:0] CAT_PERIPH    = 2'h1;
   localparam logic [1:0] SCHEME_NORMAL = 2'h0;
   localparam logic [1:0] ADDR_INC      = 2'h2;
   localparam logic [1:0] ADDR_DEC      = 2'h3;
   localparam logic [1:0] UNIT_BYTE     = 2'h0;
   localparam logic [4:0] AREA_OFF      = 5'h00;
   localparam logic [1:0] RESP_OKAY     = 2'h0;
   localparam logic [1:0] RESP_SLVERR   = 2'h2;

   // every register resets to zero: channel disarmed, nothing masked in
   localparam logic [31:0] RST_WORD = 32'h0000_0000;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'h0,
      ST_READ  = 2'h1,
      ST_WRITE = 2'h3,
      ST_DONE  = 2'h2
   } xfer_state_e;

endpackage
`default_nettype wire

// *** rtl/dma_addr_step.sv ***
`timescale 1ns/1ps
`default_nettype none
module dma_addr_step (
   input  wire logic [31:0] addr,
   input  wire logic [1:0]  mode,
   input  wire logic [4:0]  area,
   input  wire logic [1:0]  size,
   output var  logic [31:0] next_addr
);
   logic [31:0] step;
   logic [31:0] moved;
   logic [31:0] wrap;

   assign step = 32'h0000_0001 << size;
   assign wrap = (32'h0000_0001 << area) - 32'h0000_0001;

   always_comb begin
      case (mode)
         dma_chan_pkg::ADDR_INC: moved = addr + step; // RL3 RL4
         dma_chan_pkg::ADDR_DEC: moved = addr - step;
         default:                moved = addr;
      endcase
      // a zero area leaves the full address free to move
      if (area == dma_chan_pkg::AREA_OFF) begin // RL5
         next_addr = moved;
      end else begin
         next_addr = (addr & ~wrap) | (moved & wrap);
      end
   end
endmodule // dma_addr_step
`default_nettype wire

// *** rtl/dma_trigger_gate.sv ***
`timescale 1ns/1ps
`default_nettype none
module dma_trigger_gate (
   input  wire logic [255:0] request_lines,
   input  wire logic [7:0]   trigger_vector_field,
   input  wire logic         transfer_enable_bit,
   input  wire logic [1:0]   activation_category,
   input  wire logic [1:0]   transfer_scheme,
   input  wire logic [15:0]  count,
   input  wire logic         idle,
   output var  logic         start
);
   // a disarmed channel never touches the request, so it stays pending
   always_comb begin
      start = idle
         && transfer_enable_bit // RL14
         && (activation_category == dma_chan_pkg::CAT_PERIPH) // RL6
         && (transfer_scheme == dma_chan_pkg::SCHEME_NORMAL) // RL8
         && (count != 16'h0000)
         && request_lines[trigger_vector_field]; // RL2
   end
endmodule // dma_trigger_gate
`default_nettype wire

// *** rtl/dma_channel.sv ***
// Operation
// [RL1] writing 00h disarms the channel, writing 01h arms it
// [RL2] trigger comes from the request line chosen by an 8-bit vector
// [RL3] destination mode 10b increments per unit, 00b keeps it fixed
// [RL4] source mode 00b keeps it fixed, 10b increments per unit
// [RL5] repeat area of zero leaves addresses moving by mode alone
// [RL6] activation category 01b lets peripheral requests start transfers
// [RL7] unit width 00b moves one byte per unit
// [RL8] transfer scheme 00b selects normal transfers
// [RL9] with flag clear select 0 the trigger flag is cleared at start
// [RL10] end interrupt enable raises an end request when count completes
// [RL11] software source, destination and count registers drive each transfer
// [RL12] software disarms and masks before programming, arms last
// [RL13] each trigger moves one unit; count zero disarms the channel
// [RL14] triggers are ignored and left pending while disarmed
`timescale 1ns/1ps
`default_nettype none
module dma_channel (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic [7:0]   s_axi_awaddr,
   input  wire logic         s_axi_awvalid,
   output var  logic         s_axi_awready,
   input  wire logic [31:0]  s_axi_wdata,
   input  wire logic [3:0]   s_axi_wstrb,
   input  wire logic         s_axi_wvalid,
   output var  logic         s_axi_wready,
   output var  logic [1:0]   s_axi_bresp,
   output var  logic         s_axi_bvalid,
   input  wire logic         s_axi_bready,
   input  wire logic [7:0]   s_axi_araddr,
   input  wire logic         s_axi_arvalid,
   output var  logic         s_axi_arready,
   output var  logic [31:0]  s_axi_rdata,
   output var  logic [1:0]   s_axi_rresp,
   output var  logic         s_axi_rvalid,
   input  wire logic         s_axi_rready,
   input  wire logic [255:0] request_lines,
   output var  logic         flag_clear,
   output var  logic [7:0]   flag_clear_vector,
   output var  logic         mem_req,
   output var  logic         mem_we,
   output var  logic [31:0]  mem_addr,
   output var  logic [31:0]  mem_wdata,
   output var  logic [1:0]   mem_size,
   input  wire logic         mem_ack,
   input  wire logic [31:0]  mem_rdata,
   output var  logic         channel_end_interrupt
);

   typedef struct packed {
      dma_chan_pkg::xfer_state_e phase;
      logic        enable;
      logic [7:0]  vector;
      logic [15:0] addr_ctl;
      logic [15:0] fmt_ctl;
      logic        flag_sel;
      logic        end_ie;
      logic [31:0] src;
      logic [31:0] dst;
      logic [15:0] count;
      logic        stat;
      logic        mask;
      logic        aw_held;
      logic [7:0]  aw_addr;
      logic        w_held;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        mem_req;
      logic        mem_we;
      logic [31:0] mem_addr;
      logic [31:0] data;
      logic [1:0]  mem_size;
      logic        flag_clear;
      logic [7:0]  clr_vec;
      logic        irq;
   } state_s;

   state_s      st;
   state_s      next_st;
   logic        start;
   logic        wr_fire;
   logic        hw_end;
   logic        stat_clr;
   logic [32:0] wr_cur;
   logic [32:0] rd_cur;
   logic [31:0] wmask;
   logic [31:0] wv;
   logic [31:0] src_next;
   logic [31:0] dst_next;
   logic [31:0] unit_step;

   // bit 32 flags a mapped offset; unmapped reads return zero data
   function automatic logic [32:0] reg_word(input state_s s,
                                            input logic [7:0] a);
      logic [32:0] r;
      r = {1'b1, dma_chan_pkg::RST_WORD};
      case (a)
         dma_chan_pkg::OFF_ENABLE:   r[dma_chan_pkg::ENABLE_BIT] = s.enable;
         dma_chan_pkg::OFF_SOURCE:   r[7:0] = s.vector;
         dma_chan_pkg::OFF_ADDR_CTL: r[15:0] = s.addr_ctl;
         dma_chan_pkg::OFF_FORMAT:   r[15:0] = s.fmt_ctl;
         dma_chan_pkg::OFF_FLAG:     r[dma_chan_pkg::CLR_SEL_BIT] = s.flag_sel;
         dma_chan_pkg::OFF_INTEN:    r[dma_chan_pkg::END_IE_BIT] = s.end_ie;
         dma_chan_pkg::OFF_SRC_PTR:  r[31:0] = s.src;
         dma_chan_pkg::OFF_DST_PTR:  r[31:0] = s.dst;
         dma_chan_pkg::OFF_COUNT:    r[15:0] = s.count;
         dma_chan_pkg::OFF_STATUS:   r[dma_chan_pkg::END_BIT] = s.stat;
         dma_chan_pkg::OFF_MASK:     r[dma_chan_pkg::END_BIT] = s.mask;
         default:                    r[32] = 1'b0;
      endcase
      return r;
   endfunction

   function automatic logic [31:0] byte_mask(input logic [3:0] strb);
      logic [31:0] m;
      m = 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
         m[i*8 +: 8] = {8{strb[i]}};
      end
      return m;
   endfunction

   dma_trigger_gate u_gate (
      .request_lines        (request_lines),
      .trigger_vector_field (st.vector),
      .transfer_enable_bit  (st.enable),
      .activation_category  (st.fmt_ctl[dma_chan_pkg::CATEGORY_LSB +: 2]),
      .transfer_scheme      (st.fmt_ctl[dma_chan_pkg::SCHEME_LSB +: 2]),
      .count                (st.count),
      .idle                 (st.phase == dma_chan_pkg::ST_IDLE),
      .start                (start)
   );
   dma_addr_step u_src_step (
      .addr      (st.src),
      .mode      (st.addr_ctl[dma_chan_pkg::SRC_MODE_LSB +: 2]),
      .area      (st.addr_ctl[dma_chan_pkg::SRC_AREA_LSB +: 5]),
      .size      (st.mem_size),
      .next_addr (src_next)
   );
   dma_addr_step u_dst_step (
      .addr      (st.dst),
      .mode      (st.addr_ctl[dma_chan_pkg::DST_MODE_LSB +: 2]),
      .area      (st.addr_ctl[dma_chan_pkg::DST_AREA_LSB +: 5]),
      .size      (st.mem_size),
      .next_addr (dst_next)
   );
   assign wr_fire   = st.aw_held && st.w_held && !st.bvalid;
   assign hw_end    = (st.phase == dma_chan_pkg::ST_WRITE) && mem_ack
                      && (st.count == 16'h0001);
   assign wr_cur    = reg_word(st, st.aw_addr);
   assign rd_cur    = reg_word(st, s_axi_araddr);
   assign wmask     = byte_mask(st.w_strb);
   assign wv        = (wr_cur[31:0] & ~wmask) | (st.w_data & wmask);
   assign unit_step = 32'h0000_0001 << st.mem_size;
   always_comb begin
      next_st = st;
      next_st.flag_clear = 1'b0;
      stat_clr = 1'b0;

      // write channel: address and data are taken in either order
      if (st.bvalid && s_axi_bready) begin
         next_st.bvalid = 1'b0;
      end
      if (st.awready && s_axi_awvalid) begin
         next_st.aw_held = 1'b1;
         next_st.aw_addr = s_axi_awaddr;
      end
      if (st.wready && s_axi_wvalid) begin
         next_st.w_held = 1'b1;
         next_st.w_data = s_axi_wdata;
         next_st.w_strb = s_axi_wstrb;
      end
      if (wr_fire) begin
         next_st.aw_held = 1'b0;
         next_st.w_held  = 1'b0;
         next_st.bvalid  = 1'b1;
         next_st.bresp   = wr_cur[32] ? dma_chan_pkg::RESP_OKAY
                                      : dma_chan_pkg::RESP_SLVERR;
         case (st.aw_addr)
            dma_chan_pkg::OFF_ENABLE:
               next_st.enable = wv[dma_chan_pkg::ENABLE_BIT]; // RL1
            dma_chan_pkg::OFF_SOURCE:   next_st.vector = wv[7:0]; // RL2
            dma_chan_pkg::OFF_ADDR_CTL: next_st.addr_ctl = wv[15:0];
            dma_chan_pkg::OFF_FORMAT:   next_st.fmt_ctl = wv[15:0];
            dma_chan_pkg::OFF_FLAG:
               next_st.flag_sel = wv[dma_chan_pkg::CLR_SEL_BIT];
            dma_chan_pkg::OFF_INTEN:
               next_st.end_ie = wv[dma_chan_pkg::END_IE_BIT]; // RL10
            dma_chan_pkg::OFF_SRC_PTR:  next_st.src = wv; // RL11
            dma_chan_pkg::OFF_DST_PTR:  next_st.dst = wv; // RL11
            dma_chan_pkg::OFF_COUNT:    next_st.count = wv[15:0]; // RL11
            dma_chan_pkg::OFF_STATUS:
               stat_clr = st.w_data[dma_chan_pkg::END_BIT]
                          && st.w_strb[0];
            dma_chan_pkg::OFF_MASK:
               next_st.mask = wv[dma_chan_pkg::END_BIT];
            default: ;
         endcase
      end
      next_st.awready = !next_st.aw_held && !next_st.bvalid;
      next_st.wready  = !next_st.w_held && !next_st.bvalid;

      // read channel
      if (st.rvalid && s_axi_rready) begin
         next_st.rvalid = 1'b0;
      end
      if (st.arready && s_axi_arvalid) begin
         next_st.rvalid = 1'b1;
         next_st.rdata  = rd_cur[31:0];
         next_st.rresp  = rd_cur[32] ? dma_chan_pkg::RESP_OKAY
                                     : dma_chan_pkg::RESP_SLVERR;
      end
      next_st.arready = !next_st.rvalid;

      // transfer engine; its updates win over a same-cycle software write
      case (st.phase)
         dma_chan_pkg::ST_IDLE: begin
            if (start) begin // RL13
               next_st.phase    = dma_chan_pkg::ST_READ;
               next_st.mem_req  = 1'b1;
               next_st.mem_we   = 1'b0;
               next_st.mem_addr = st.src; // RL11
               next_st.mem_size =
                  st.fmt_ctl[dma_chan_pkg::UNIT_LSB +: 2]; // RL7
               if (!st.flag_sel) begin // RL9
                  next_st.flag_clear = 1'b1;
                  next_st.clr_vec    = st.vector;
               end
            end
         end
         dma_chan_pkg::ST_READ: begin
            if (mem_ack) begin
               next_st.phase    = dma_chan_pkg::ST_WRITE;
               next_st.data     = mem_rdata;
               next_st.mem_we   = 1'b1;
               next_st.mem_addr = st.dst; // RL11
            end
         end
         dma_chan_pkg::ST_WRITE: begin
            if (mem_ack) begin
               next_st.phase   = dma_chan_pkg::ST_DONE;
               next_st.mem_req = 1'b0;
               next_st.mem_we  = 1'b0;
               next_st.src     = src_next; // RL4
               next_st.dst     = dst_next; // RL3
               next_st.count   = st.count - 16'h0001; // RL11
               if (hw_end) begin
                  next_st.enable = 1'b0; // RL13
               end
            end
         end
         // one idle cycle lets the cleared request flag settle
         dma_chan_pkg::ST_DONE: next_st.phase = dma_chan_pkg::ST_IDLE;
         default: next_st.phase = dma_chan_pkg::ST_IDLE;
      endcase
      // a completion with end_ie set in the same cycle as a clear keeps the bit set
      next_st.stat = (st.stat && !stat_clr) || (hw_end && st.end_ie); // RL10
      next_st.irq  = next_st.stat && next_st.mask;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign s_axi_awready         = st.awready;
   assign s_axi_wready          = st.wready;
   assign s_axi_bvalid          = st.bvalid;
   assign s_axi_bresp           = st.bresp;
   assign s_axi_arready         = st.arready;
   assign s_axi_rvalid          = st.rvalid;
   assign s_axi_rdata           = st.rdata;
   assign s_axi_rresp           = st.rresp;
   assign flag_clear            = st.flag_clear;
   assign flag_clear_vector     = st.clr_vec;
   assign mem_req               = st.mem_req;
   assign mem_we                = st.mem_we;
   assign mem_addr              = st.mem_addr;
   assign mem_wdata             = st.data;
   assign mem_size              = st.mem_size;
   assign channel_end_interrupt = st.irq;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_enable_clear: assert property (wr_fire && st.w_strb[0]  // RL1
      && st.aw_addr == dma_chan_pkg::OFF_ENABLE && !st.w_data[0]
      |=> !st.enable) else $error("enable not cleared by write");
   a_enable_set: assert property (wr_fire && st.w_strb[0]  // RL1
      && st.aw_addr == dma_chan_pkg::OFF_ENABLE && st.w_data[0] && !hw_end
      |=> st.enable) else $error("enable not set by write");
   a_vector_gate: assert property (st.phase == dma_chan_pkg::ST_IDLE  // RL2
      && !request_lines[st.vector] |=> st.phase == dma_chan_pkg::ST_IDLE)
      else $error("started without selected request");
   a_dest_step: assert property (st.phase == dma_chan_pkg::ST_WRITE  // RL3
      && mem_ack && st.addr_ctl[7:0] == 8'h80
      |=> st.dst == $past(st.dst) + $past(unit_step))
      else $error("destination did not increment");
   a_src_fixed: assert property (st.phase == dma_chan_pkg::ST_WRITE  // RL4
      && mem_ack && st.addr_ctl[15:14] == 2'h0
      && st.addr_ctl[12:8] == 5'h00 |=> $stable(st.src))
      else $error("fixed source moved");
   a_category: assert property (st.phase == dma_chan_pkg::ST_IDLE  // RL6
      && st.fmt_ctl[1:0] != 2'h1 |=> st.phase == dma_chan_pkg::ST_IDLE)
      else $error("started without peripheral category");
   a_byte_unit: assert property (start && st.fmt_ctl[9:8] == 2'h0  // RL7
      |=> st.mem_req && st.mem_size == 2'h0 [*2])
      else $error("unit not a byte");
   a_normal_only: assert property (st.phase == dma_chan_pkg::ST_IDLE  // RL8
      && st.fmt_ctl[13:12] != 2'h0 |=> st.phase == dma_chan_pkg::ST_IDLE)
      else $error("started outside normal scheme");
   a_flag_clear: assert property (start && !st.flag_sel  // RL9
      |=> st.flag_clear && st.clr_vec == $past(st.vector) ##1 !st.flag_clear)
      else $error("request flag not cleared once");
   a_end_irq: assert property (hw_end && st.end_ie  // RL10
      |=> st.stat && channel_end_interrupt == st.mask)
      else $error("end status or interrupt missing");
   a_count_dec: assert property (st.phase == dma_chan_pkg::ST_WRITE  // RL11
      && mem_ack |=> st.count == $past(st.count) - 16'h0001)
      else $error("count not decremented");
   a_end_disarm: assert property (hw_end  // RL13
      |=> !st.enable && st.phase == dma_chan_pkg::ST_DONE)
      else $error("channel still armed at count zero");
   a_disarmed_idle: assert property (!st.enable  // RL14
      && st.phase == dma_chan_pkg::ST_IDLE |=> !st.mem_req && !st.flag_clear)
      else $error("disarmed channel acted on request");

endmodule // dma_channel
`default_nettype wire

// *** sim/serial_peripheral_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// request flags of the serial peripheral plus the byte memory it sits in
module serial_peripheral_model (
   input  wire logic         aclk,
   input  wire logic         set_req,
   input  wire logic [7:0]   set_vec,
   input  wire logic         slow,
   input  wire logic         flag_clear,
   input  wire logic [7:0]   flag_clear_vector,
   input  wire logic         mem_req,
   input  wire logic         mem_we,
   input  wire logic [31:0]  mem_addr,
   input  wire logic [31:0]  mem_wdata,
   input  wire logic [1:0]   mem_size,
   output var  logic         mem_ack,
   output var  logic [31:0]  mem_rdata,
   output var  logic [255:0] request_lines
);
   logic [7:0] mem [256];
   logic [1:0] size_or;
   logic [1:0] wait_n;
   int         writes;

   initial begin
      mem_ack = 1'b0;
      mem_rdata = 32'h0000_0000;
      request_lines = '0;
      size_or = 2'h0;
      wait_n = 2'h0;
      writes = 0;
   end

   always @(posedge aclk) begin
      if (set_req)
         request_lines[set_vec] <= 1'b1;
      // a flag stays pending until the channel clears it
      if (flag_clear)
         request_lines[flag_clear_vector] <= 1'b0;
      mem_ack <= 1'b0;
      // idle data bus flips so a sample outside the ack cannot pass
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
         if (slow && wait_n != 2'h3) begin
            wait_n <= wait_n + 2'h1;
         end else begin
            wait_n <= 2'h0;
            mem_ack <= 1'b1;
            size_or <= size_or | mem_size;
            if (mem_we) begin
               mem[mem_addr[7:0]] <= mem_wdata[7:0];
               writes <= writes + 1;
            end else begin
               mem_rdata <= {24'h00_0000, mem[mem_addr[7:0]]};
            end
         end
      end
   end
endmodule // serial_peripheral_model
`default_nettype wire

// *** sim/peripheral_triggered_transfer_channel_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module peripheral_triggered_transfer_channel_test;
   logic         aclk = 1'b0;
   logic         aresetn = 1'b0;
   logic [7:0]   s_axi_awaddr = 8'h00;
   logic [7:0]   s_axi_araddr = 8'h00;
   logic [31:0]  s_axi_wdata = 32'h0000_0000;
   logic         s_axi_awvalid = 1'b0;
   logic         s_axi_wvalid = 1'b0;
   logic         s_axi_bready = 1'b0;
   logic         s_axi_arvalid = 1'b0;
   logic         s_axi_rready = 1'b0;
   logic         s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic         s_axi_arready, s_axi_rvalid;
   logic [1:0]   s_axi_bresp, s_axi_rresp, mem_size;
   logic [31:0]  s_axi_rdata, mem_addr, mem_wdata, mem_rdata;
   logic         flag_clear, mem_req, mem_we, mem_ack;
   logic         channel_end_interrupt;
   logic [7:0]   flag_clear_vector;
   logic [255:0] request_lines;
   logic         set_req = 1'b0;
   logic [7:0]   set_vec = 8'h00;
   logic         slow = 1'b0;
   logic [31:0]  fmts [3] = '{32'h0000_0000, 32'h0000_0002, 32'h0000_1001};
   int           errors = 0;
   int           n_tests = 0;

   always #2 aclk = ~aclk;

   dma_channel i_dut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .request_lines(request_lines),
      .flag_clear(flag_clear), .flag_clear_vector(flag_clear_vector),
      .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_size(mem_size), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata), .channel_end_interrupt(channel_end_interrupt)
   );

   serial_peripheral_model i_per (
      .aclk(aclk), .set_req(set_req), .set_vec(set_vec), .slow(slow),
      .flag_clear(flag_clear), .flag_clear_vector(flag_clear_vector),
      .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_size(mem_size), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata), .request_lines(request_lines)
   );

   task automatic complete_run();
      if (errors == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge aclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er = dma_chan_pkg::RESP_OKAY);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      check(32'(s_axi_bresp), 32'(er));
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp,
      input logic [1:0] er = dma_chan_pkg::RESP_OKAY);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      check(s_axi_rdata, exp);
      check(32'(s_axi_rresp), 32'(er));
   endtask

   task automatic raise(input logic [7:0] v);
      @(posedge aclk);
      set_req <= 1'b1;
      set_vec <= v;
      @(posedge aclk);
      set_req <= 1'b0;
   endtask

   // bounded wait for the memory side to see n unit writes
   task automatic wait_wr(input int n);
      int k;
      k = 0;
      while (i_per.writes != n && k < 200) begin
         @(posedge aclk);
         k++;
      end
      check(32'(i_per.writes), 32'(n));
   endtask

   task automatic setup(input logic [7:0] v, input logic [31:0] am,
      input logic [31:0] sp, input logic [31:0] dp, input logic [31:0] n);
      wr(dma_chan_pkg::OFF_MASK, 32'h0000_0000);
      wr(dma_chan_pkg::OFF_ENABLE, 32'h0000_0000);
      wr(dma_chan_pkg::OFF_SOURCE, 32'(v));
      wr(dma_chan_pkg::OFF_ADDR_CTL, am);
      wr(dma_chan_pkg::OFF_FORMAT, 32'h0000_0001);
      wr(dma_chan_pkg::OFF_FLAG, 32'h0000_0000);
      wr(dma_chan_pkg::OFF_SRC_PTR, sp);
      wr(dma_chan_pkg::OFF_DST_PTR, dp);
      wr(dma_chan_pkg::OFF_COUNT, n);
      wr(dma_chan_pkg::OFF_INTEN, 32'h0000_0010);
      wr(dma_chan_pkg::OFF_MASK, 32'h0000_0001);
   endtask

   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      idle(2);
      for (int i = 0; i < 11; i++)
         rd(8'(4 * i), 32'h0000_0000);
      rd(8'h2c, 32'h0000_0000, dma_chan_pkg::RESP_SLVERR);
      wr(8'h2c, 32'h0000_00ff, dma_chan_pkg::RESP_SLVERR);
      // receive side: fixed source register into a rising buffer
      i_per.mem[8'h10] = 8'h5a;
      setup(8'd241, 32'h0000_0080, 32'h0000_0010, 32'h0000_0020, 32'd3);
      raise(8'd241);
      idle(20);
      check(32'(i_per.writes), 32'd0);
      check(32'(request_lines[241]), 32'd1);
      wr(dma_chan_pkg::OFF_ENABLE, 32'h0000_0001);
      wait_wr(1);
      check(32'(request_lines[241]), 32'd0);
      i_per.mem[8'h10] = 8'ha5;
      raise(8'd241);
      wait_wr(2);
      i_per.mem[8'h10] = 8'h3c;
      raise(8'd241);
      wait_wr(3);
      check(32'(i_per.mem[8'h20]), 32'h0000_005a);
      check(32'(i_per.mem[8'h21]), 32'h0000_00a5);
      check(32'(i_per.mem[8'h22]), 32'h0000_003c);
      rd(dma_chan_pkg::OFF_COUNT, 32'h0000_0000);
      rd(dma_chan_pkg::OFF_ENABLE, 32'h0000_0000);
      rd(dma_chan_pkg::OFF_SRC_PTR, 32'h0000_0010);
      rd(dma_chan_pkg::OFF_DST_PTR, 32'h0000_0023);
      rd(dma_chan_pkg::OFF_STATUS, 32'h0000_0001);
      check(32'(channel_end_interrupt), 32'd1);
      raise(8'd241);
      idle(20);
      check(32'(i_per.writes), 32'd3);
      wr(dma_chan_pkg::OFF_MASK, 32'h0000_0000);
      idle(2);
      check(32'(channel_end_interrupt), 32'd0);
      wr(dma_chan_pkg::OFF_MASK, 32'h0000_0001);
      wr(dma_chan_pkg::OFF_STATUS, 32'h0000_0001);
      idle(2);
      check(32'(channel_end_interrupt), 32'd0);
      rd(dma_chan_pkg::OFF_STATUS, 32'h0000_0000);
      // transmit side with a slow memory; 241 stays pending and must not fire
      slow <= 1'b1;
      i_per.mem[8'h30] = 8'h11;
      i_per.mem[8'h31] = 8'h22;
      setup(8'd242, 32'h0000_8000, 32'h0000_0030, 32'h0000_0011, 32'd2);
      wr(dma_chan_pkg::OFF_ENABLE, 32'h0000_0001);
      idle(20);
      check(32'(i_per.writes), 32'd3);
      raise(8'd242);
      wait_wr(4);
      raise(8'd242);
      wait_wr(5);
      check(32'(i_per.mem[8'h11]), 32'h0000_0022);
      rd(dma_chan_pkg::OFF_SRC_PTR, 32'h0000_0032);
      rd(dma_chan_pkg::OFF_DST_PTR, 32'h0000_0011);
      // only category 01 with the normal scheme may start a unit
      raise(8'd242);
      wr(dma_chan_pkg::OFF_FORMAT, fmts[0]);
      wr(dma_chan_pkg::OFF_COUNT, 32'h0000_0001);
      wr(dma_chan_pkg::OFF_ENABLE, 32'h0000_0001);
      for (int i = 0; i < 3; i++) begin
         wr(dma_chan_pkg::OFF_FORMAT, fmts[i]);
         idle(20);
         check(32'(i_per.writes), 32'd5);
      end
      wr(dma_chan_pkg::OFF_ADDR_CTL, 32'h0000_c000);
      wr(dma_chan_pkg::OFF_FORMAT, 32'h0000_0001);
      wait_wr(6);
      rd(dma_chan_pkg::OFF_SRC_PTR, 32'h0000_0031);
      check(32'(i_per.size_or), 32'(dma_chan_pkg::UNIT_BYTE));
      complete_run();
   end

   initial begin
      repeat (20000) @(posedge aclk);
      errors++;
      complete_run();
   end
endmodule // peripheral_triggered_transfer_channel_test
`default_nettype wire
